// file: core/sar_adc_pkg.sv
// shared constants and types for the converter control and readout
// assumes a 250 MHz system clock; the serial clock arrives from the host
package sar_adc_pkg;
  // ===========================================
  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int POR_WAIT_NS   = 20000;
  localparam int CONV_MAX_NS   = 2500;
  localparam int ACQ_START_NS  = 750;
  // least times round up, longest times round down
  localparam int POR_WAIT_CYC  = (POR_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CONV_CYC      = CONV_MAX_NS / CLK_PERIOD_NS;
  localparam int ACQ_CYC       = (ACQ_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 13;
  // ===========================================
  // result word
  localparam int RES_W         = 16;
  localparam logic [15:0] RES_RESET = 16'h0000;
  localparam logic [4:0] BIT_RESET  = 5'h00;
  // ===========================================
  // conversion states, one-hot
  typedef enum logic [3:0] {
    ST_INIT  = 4'h1,
    ST_IDLE  = 4'h2,
    ST_CONV  = 4'h4,
    ST_PDOWN = 4'h8
  } state_e;
  // status seen by the surrounding chip
  typedef struct packed {
    logic ready;
    logic acquiring;
    logic powered_down;
  } status_s;
endpackage

// file: core/sar_adc_convert_readout.sv
// conversion control and serial readout of a 16-bit sar converter
// assumes convert_start, the shared pin, supply flag and mode strap are
// asynchronous pins; sample_code_i comes from logic on clk_i
module sar_adc_convert_readout #(
  parameter int POR_WAIT = sar_adc_pkg::POR_WAIT_CYC,
  parameter int RES_W    = sar_adc_pkg::RES_W
) (
  input  wire logic                clk_i,
  input  wire logic                reset_i,
  input  wire logic                ce_i,
  input  wire logic                supply_low_i,
  input  wire logic                cascade_sel_i,
  input  wire logic                convert_start_i,
  input  wire logic [RES_W-1:0]    sample_code_i,
  output logic                     busy_o,
  output sar_adc_pkg::status_s     status_o,
  input  wire logic                sck_i,
  input  wire logic                read_enable_or_cascade_input_i,
  output logic                     sdo_o,
  output logic                     sdo_oe_o
);

  // ===========================================
  // pin synchronisers
  // first stage of each pair feeds only its second stage
  logic [1:0] cnv_sync_q;
  logic [1:0] rdl_sync_q;
  logic [1:0] low_sync_q;
  logic [1:0] chain_sync_q;
  logic       cnv_prev_q;
  logic       rdl_prev_q;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cnv_sync_q   <= 2'h0;
      rdl_sync_q   <= 2'h3;
      low_sync_q   <= 2'h3;
      chain_sync_q <= 2'h0;
      cnv_prev_q   <= 1'b0;
      rdl_prev_q   <= 1'b1;
    end else if (ce_i) begin
      cnv_sync_q   <= {cnv_sync_q[0], convert_start_i};
      rdl_sync_q   <= {rdl_sync_q[0], read_enable_or_cascade_input_i};
      low_sync_q   <= {low_sync_q[0], supply_low_i};
      chain_sync_q <= {chain_sync_q[0], cascade_sel_i};
      cnv_prev_q   <= cnv_sync_q[1];
      rdl_prev_q   <= rdl_sync_q[1];
    end
  end

  // ===========================================
  // decoded pin events
  wire logic cnv_s      = cnv_sync_q[1];
  wire logic rdl_s      = rdl_sync_q[1];
  wire logic chain_s    = chain_sync_q[1];
  wire logic supply_bad = low_sync_q[1];
  wire logic start_edge = cnv_s & ~cnv_prev_q;
  wire logic rdl_fall   = rdl_prev_q & ~rdl_s;

  // ===========================================
  // conversion state machine
  sar_adc_pkg::state_e            state_q;
  sar_adc_pkg::state_e            state_d;
  logic [sar_adc_pkg::CNT_W-1:0]  cnt_q;
  logic [sar_adc_pkg::CNT_W-1:0]  cnt_d;
  logic [RES_W-1:0]               sample_q;
  logic [RES_W-1:0]               result_q;
  logic                           load_tog_q;
  logic                           acq_q;
  logic                           ack_q;
  logic [1:0]                     ack_sync_q;
  logic [sar_adc_pkg::CNT_W-1:0]  busy_run_q;

  localparam logic [sar_adc_pkg::CNT_W-1:0] POR_LAST  = sar_adc_pkg::CNT_W'(POR_WAIT - 1);
  localparam logic [sar_adc_pkg::CNT_W-1:0] CONV_LAST = sar_adc_pkg::CNT_W'(sar_adc_pkg::CONV_CYC - 1);
  localparam logic [sar_adc_pkg::CNT_W-1:0] ACQ_AT    = sar_adc_pkg::CNT_W'(sar_adc_pkg::ACQ_CYC);
  localparam logic [sar_adc_pkg::CNT_W-1:0] CONV_LEN  = sar_adc_pkg::CNT_W'(sar_adc_pkg::CONV_CYC);

  wire logic in_init  = (state_q == sar_adc_pkg::ST_INIT);
  wire logic in_idle  = (state_q == sar_adc_pkg::ST_IDLE);
  wire logic in_conv  = (state_q == sar_adc_pkg::ST_CONV);
  wire logic in_pdown = (state_q == sar_adc_pkg::ST_PDOWN);
  wire logic por_done = in_init & (cnt_q == POR_LAST);
  wire logic conv_end = in_conv & (cnt_q == CONV_LAST);
  wire logic go       = in_idle & start_edge;
  // a finished word or a fresh enable both re-present the top bit
  wire logic reload   = conv_end | (rdl_fall & ~chain_s);
  // a word still waiting for its first serial edge is not toggled again,
  // since two reloads with the serial clock stopped would cancel out
  wire logic pend     = (load_tog_q != ack_sync_q[1]);

  // next state; starts are only taken from idle
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q + 1'b1;
    unique case (state_q)
      sar_adc_pkg::ST_INIT: begin
        if (por_done) begin
          state_d = sar_adc_pkg::ST_IDLE;
        end
      end
      sar_adc_pkg::ST_IDLE: begin
        cnt_d = '0;
        if (go) begin
          state_d = sar_adc_pkg::ST_CONV;
        end
      end
      sar_adc_pkg::ST_CONV: begin
        // further start edges are not looked at here
        if (conv_end) begin
          cnt_d   = '0;
          state_d = cnv_s ? sar_adc_pkg::ST_PDOWN : sar_adc_pkg::ST_IDLE;
        end
      end
      sar_adc_pkg::ST_PDOWN: begin
        cnt_d = '0;
        if (!cnv_s) begin
          state_d = sar_adc_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = sar_adc_pkg::ST_INIT;
        cnt_d   = '0;
      end
    endcase
  end

  // supply loss forces a full reinitialisation
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_q <= sar_adc_pkg::ST_INIT;
      cnt_q   <= '0;
    end else if (ce_i) begin
      if (supply_bad) begin
        state_q <= sar_adc_pkg::ST_INIT;
        cnt_q   <= '0;
      end else begin
        state_q <= state_d;
        cnt_q   <= cnt_d;
      end
    end
  end

  // sample is held at start, word published as busy falls
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      sample_q   <= sar_adc_pkg::RES_RESET;
      result_q   <= sar_adc_pkg::RES_RESET;
      load_tog_q <= 1'b0;
    end else if (ce_i) begin
      if (go) begin
        sample_q <= sample_code_i;
      end
      if (conv_end) begin
        result_q <= sample_q;
      end
      if (reload && !pend) begin
        load_tog_q <= ~load_tog_q;
      end
    end
  end

  // serial acknowledge comes back over two flops; the host keeps the
  // serial clock low long enough around a reload for it to settle
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ack_sync_q <= 2'h0;
    end else if (ce_i) begin
      ack_sync_q <= {ack_sync_q[0], ack_q};
    end
  end

  // acquisition overlaps the tail of the conversion
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      acq_q <= 1'b0;
    end else if (ce_i) begin
      if (go || supply_bad) begin
        acq_q <= 1'b0;
      end else if (in_conv && cnt_q == ACQ_AT) begin
        acq_q <= 1'b1;
      end
    end
  end

  // ===========================================
  // status outputs
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      busy_o   <= 1'b0;
      status_o <= '0;
      sdo_oe_o <= 1'b0;
    end else if (ce_i) begin
      busy_o                <= (state_d == sar_adc_pkg::ST_CONV) & ~supply_bad;
      status_o.ready        <= ~in_init;
      status_o.acquiring    <= acq_q;
      status_o.powered_down <= in_pdown;
      sdo_oe_o              <= chain_s | ~rdl_s;
    end
  end

  // ===========================================
  // serial clock domain
  // result_q and load_tog_q are static for the whole readout because the
  // host keeps the serial clock low around each reload, so they are
  // taken here as a held word with load_tog_q as its qualifier; ack_q
  // goes back over two flops so a pending word is never toggled away
  logic [1:0]       srst_sync_q;
  logic [RES_W-1:0] shift_q;

  always_ff @(posedge sck_i) begin
    srst_sync_q <= {srst_sync_q[0], reset_i};
  end

  wire logic fresh = (ack_q != load_tog_q);

  // every rising edge shifts; shared pin is the upstream bit in cascade
  always_ff @(posedge sck_i) begin
    if (srst_sync_q[1]) begin
      ack_q   <= 1'b0;
      shift_q <= sar_adc_pkg::RES_RESET;
    end else if (fresh) begin
      ack_q   <= load_tog_q;
      shift_q <= {result_q[RES_W-2:0], read_enable_or_cascade_input_i};
    end else begin
      shift_q <= {shift_q[RES_W-2:0], read_enable_or_cascade_input_i};
    end
  end

  // top bit straight from the word until the first rising edge
  assign sdo_o = fresh ? result_q[RES_W-1] : shift_q[RES_W-1];

  // ===========================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i || !ce_i);

  // helper: length of the current busy run, so the conversion bound is
  // checked by a counter instead of a long repetition
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      busy_run_q <= '0;
    end else if (ce_i) begin
      if (busy_o) begin
        busy_run_q <= busy_run_q + 1'b1;
      end else begin
        busy_run_q <= '0;
      end
    end
  end

  sequence s_start;
    in_idle && start_edge && !supply_bad;
  endsequence
  sequence s_done;
    $fell(busy_o);
  endsequence
  // a finished conversion, not one cut short by supply loss
  sequence s_done_clean;
    $fell(busy_o) && !$past(supply_bad);
  endsequence
  sequence s_wake;
    in_pdown && !cnv_s && !supply_bad;
  endsequence

  AST_SUPPLY_INIT: assert property (supply_bad |=> in_init)
    else $error("supply loss did not reinitialise");
  AST_START_BUSY: assert property (s_start |=> busy_o)
    else $error("start edge did not raise busy");
  AST_NO_RESTART: assert property (in_conv && start_edge && !conv_end && !supply_bad |=> cnt_q == $past(cnt_q) + 1'b1)
    else $error("conversion restarted");
  AST_BUSY_SPAN: assert property (s_start ##1 busy_o |-> busy_o[*8])
    else $error("busy dropped early");
  AST_CONV_BOUND: assert property (s_start |-> ##[1:640] !busy_o)
    else $error("conversion longer than limit");
  AST_ACQ: assert property (in_conv && cnt_q == ACQ_AT && !supply_bad |=> acq_q)
    else $error("acquisition not started");
  AST_PDOWN: assert property (s_done_clean and cnv_s |-> ##1 status_o.powered_down)
    else $error("no power-down after conversion");
  AST_RELOAD: assert property (s_done_clean |-> load_tog_q != $past(load_tog_q, 2) || $past(pend, 2))
    else $error("word not presented at busy fall");
  AST_NORMAL_OE: assert property (!chain_s && rdl_s |=> !sdo_oe_o)
    else $error("output driven while not enabled");
  AST_CHAIN_OE: assert property (chain_s |=> sdo_oe_o)
    else $error("cascade output not driven");
  AST_OE_ENABLED: assert property (!chain_s && !rdl_s |=> sdo_oe_o)
    else $error("output not driven while enabled");

  // state machine checks
  AST_INIT_QUIET: assert property (in_init |=> !busy_o)
    else $error("busy during initialisation");
  AST_INIT_NOT_READY: assert property (in_init |=> !status_o.ready)
    else $error("ready shown during initialisation");
  AST_SAMPLE_AT_GO: assert property (go |=> sample_q == $past(sample_code_i))
    else $error("sample not held at start");
  AST_BUSY_START_ONLY: assert property ($rose(busy_o) |-> $past(go))
    else $error("busy rose without a taken start");
  AST_IDLE_QUIET: assert property (in_idle && !go |=> !busy_o)
    else $error("busy while idle");
  AST_BUSY_FULL: assert property (s_done_clean |-> busy_run_q == CONV_LEN)
    else $error("busy run length wrong");
  AST_BUSY_MAX: assert property (busy_run_q <= CONV_LEN)
    else $error("busy run over the conversion limit");
  AST_ACQ_CLEAR: assert property (go |=> !acq_q)
    else $error("acquisition flag not cleared at start");
  AST_PDOWN_QUIET: assert property (in_pdown |=> !busy_o)
    else $error("busy while powered down");
  AST_PDOWN_HOLD: assert property (in_pdown && cnv_s && !supply_bad |=> in_pdown)
    else $error("power-down left while convert pin high");
  AST_WAKE: assert property (s_wake |=> in_idle)
    else $error("no wake on convert pin low");
  AST_STATUS_PDOWN: assert property (in_pdown |=> status_o.powered_down)
    else $error("power-down status missing");
  AST_RESULT_HELD: assert property (in_pdown |=> result_q == $past(result_q))
    else $error("result changed while powered down");

  // serial hand-over checks
  AST_RESULT_LOAD: assert property (conv_end |=> result_q == $past(sample_q))
    else $error("result not published at conversion end");
  AST_END_RELOAD: assert property (conv_end && !pend |=> load_tog_q != $past(load_tog_q))
    else $error("word not re-presented at conversion end");
  AST_ENABLE_RELOAD: assert property (!chain_s && rdl_fall && !pend |=> load_tog_q != $past(load_tog_q))
    else $error("word not re-presented at enable fall");
  AST_CHAIN_HOLD: assert property (chain_s && !conv_end |=> load_tog_q == $past(load_tog_q))
    else $error("cascade word re-presented by shared pin");

endmodule

// file: testbench/host_model.sv
// host model: drives convert pin, serial clock and the shared pin, reads sdo
// assumes the bench calls one task at a time; sck stands still outside frames
module host_model (
  input  wire logic clk_i,
  input  wire logic sdo_i,
  input  wire logic sdo_oe_i,
  output logic      convert_start_o,
  output logic      sck_o,
  output logic      read_enable_or_cascade_input_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ========================================
  // released pin shows the inverse of its last driven value, never a lucky match
  logic last_q = 1'b0;
  wire  line_w = sdo_oe_i ? sdo_i : ~last_q;
  always @(sdo_i) if (sdo_oe_i) last_q = sdo_i;
  // a few sck beats at start carry the reset into the link side
  initial begin
    convert_start_o = 1'b0;
    sck_o = 1'b0;
    read_enable_or_cascade_input_o = 1'b0;
    #13;
    repeat (4) begin
      sck_o = 1'b1;
      #32 sck_o = 1'b0;
      #32;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // second edge lands within 40ns, the only move allowed mid conversion
  task automatic start();
    tick(1);
    convert_start_o = 1'b1;
    tick(2);
    convert_start_o = 1'b0;
    tick(2);
    convert_start_o = 1'b1;
  endtask
  task automatic wake();
    convert_start_o = 1'b0;
    tick(55);
  endtask
  task automatic set_rd(input logic v);
    tick(1);
    read_enable_or_cascade_input_o = v;
  endtask
  // 64ns sck; bit sampled at each falling edge; up feeds the shared pin if casc
  task automatic read(input int n, input logic casc, input logic [15:0] up, output logic [31:0] w);
    w = '0;
    if (casc) read_enable_or_cascade_input_o = up[15];
    #20;
    w[n-1] = line_w;
    for (int k = 1; k < n; k++) begin
      sck_o = 1'b1;
      #32 sck_o = 1'b0;
      if (casc) read_enable_or_cascade_input_o = (k < 16) ? up[15-k] : 1'b0;
      w[n-1-k] = line_w;
      #32;
    end
  endtask
endmodule

// file: testbench/tb_top.sv
// self-checking bench for the converter control and serial readout
// assumes host_model stands at the pins; por count shortened to 20 cycles
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int POR = 20;
  logic                 clk_i = 1'b0;
  logic                 reset_i = 1'b1;
  logic                 supply_low_i = 1'b0;
  logic                 cascade_sel_i = 1'b0;
  logic [15:0]          sample_code_i = 16'h0000;
  logic                 busy_o, sdo_o, sdo_oe_o, cnv_w, sck_w, rd_w;
  logic [31:0]          w;
  sar_adc_pkg::status_s status_o;
  int                   error_cnt = 0;
  int                   compares = 0;
  initial forever #2 clk_i = ~clk_i;
  // ========================================
  sar_adc_convert_readout #(.POR_WAIT(POR), .RES_W(16)) i_sar_adc_convert_readout (.clk_i(clk_i),
    .reset_i(reset_i), .ce_i(1'b1), .supply_low_i(supply_low_i), .cascade_sel_i(cascade_sel_i),
    .convert_start_i(cnv_w), .sample_code_i(sample_code_i), .busy_o(busy_o), .status_o(status_o),
    .sck_i(sck_w), .read_enable_or_cascade_input_i(rd_w), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o));
  host_model i_host_model (.clk_i(clk_i), .sdo_i(sdo_o), .sdo_oe_i(sdo_oe_o), .convert_start_o(cnv_w),
    .sck_o(sck_w), .read_enable_or_cascade_input_o(rd_w));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    if (error_cnt == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // no start is offered before ready, so the init wait is honoured
  task automatic wait_ready();
    for (int n = 0; n < POR + 20 && status_o.ready !== 1'b1; n++) tick(1);
    chk(status_o.ready, 1'b1);
  endtask
  // one conversion with a refused second edge; ends powered down, cnv high
  task automatic do_conv(input logic [15:0] code);
    int cyc;
    int acq;
    sample_code_i = code;
    // start runs beside the busy watch so the busy span is counted whole
    fork
      i_host_model.start();
    join_none
    for (int n = 0; n < 8 && busy_o !== 1'b1; n++) tick(1);
    chk(busy_o, 1'b1);
    cyc = 0;
    acq = 0;
    while (busy_o === 1'b1 && cyc < 700) begin
      tick(1);
      cyc++;
      if (status_o.acquiring === 1'b1 && acq == 0) acq = cyc;
    end
    chk(cyc, sar_adc_pkg::CONV_CYC);
    chk(acq >= 186 && acq <= 190, 1'b1);
    tick(2);
    chk(status_o.powered_down, 1'b1);
  endtask
  task automatic t_init();
    chk(status_o.ready, 1'b0);
    wait_ready();
  endtask
  task automatic t_normal();
    do_conv(16'ha5c3);
    i_host_model.read(16, 1'b0, 16'h0000, w);
    chk(w[15:0], 16'ha5c3);
    i_host_model.wake();
    chk(status_o.powered_down, 1'b0);
  endtask
  task automatic t_enable();
    i_host_model.set_rd(1'b1);
    tick(6);
    chk(sdo_oe_o, 1'b0);
    i_host_model.set_rd(1'b0);
    tick(6);
    chk(sdo_oe_o, 1'b1);
    i_host_model.read(16, 1'b0, 16'h0000, w);
    chk(w[15:0], 16'ha5c3);
  endtask
  task automatic t_cascade();
    cascade_sel_i = 1'b1;
    i_host_model.set_rd(1'b1);
    tick(6);
    chk(sdo_oe_o, 1'b1);
    do_conv(16'h3c96);
    i_host_model.read(32, 1'b1, 16'hb14e, w);
    chk(w, 32'h3c96b14e);
    i_host_model.wake();
  endtask
  task automatic t_supply();
    supply_low_i = 1'b1;
    tick(6);
    chk(status_o.ready, 1'b0);
    supply_low_i = 1'b0;
    wait_ready();
  endtask
  // watchdog well past the few thousand cycles the tests need
  initial begin
    #100000;
    error_cnt++;
    end_sim();
  end
  initial begin
    tick(4);
    reset_i = 1'b0;
    tick(1);
    t_init();
    t_normal();
    t_enable();
    t_cascade();
    t_supply();
    end_sim();
  end
endmodule
